// ---- shared/dpt_pkg.sv ----
// constants for the dancer pid speed trim block
package dpt_pkg;
  // register byte offsets
  localparam logic [7:0] A_ACT = 8'h00;
  localparam logic [7:0] A_UPR = 8'h04;
  localparam logic [7:0] A_LWR = 8'h08;
  localparam logic [7:0] A_SPT = 8'h0c;
  localparam logic [7:0] A_IN0 = 8'h10;
  localparam logic [7:0] A_OSA = 8'h24;
  localparam logic [7:0] A_OSB = 8'h28;
  localparam logic [7:0] A_SCL = 8'h2c;
  localparam logic [7:0] A_CTL = 8'h30;
  localparam logic [7:0] A_THM = 8'h34;
  localparam logic [7:0] A_BIA = 8'h38;
  localparam logic [7:0] A_GAI = 8'h3c;
  localparam logic [7:0] A_ASW = 8'h40;
  localparam logic [7:0] A_SUS = 8'h44;
  localparam logic [7:0] A_STA = 8'h48;
  localparam logic [7:0] A_FRQ = 8'h4c;
  localparam int N_IN = 5;
  // field positions
  localparam int B_NET = 0;
  localparam int B_UP = 0;
  localparam int B_DN = 1;
  localparam int B_FW = 2;
  localparam int B_ACT = 3;
  localparam int B_HLD = 4;
  // setting codes
  localparam logic [15:0] NOFN = 16'h270f;
  localparam logic [7:0] C_ACT0 = 8'h28;
  localparam logic [7:0] C_ACT3 = 8'h2b;
  localparam logic [7:0] C_SEL = 8'h0e;
  localparam logic [7:0] C_DN = 8'h0e;
  localparam logic [7:0] C_UP = 8'h0f;
  localparam logic [7:0] C_FW = 8'h10;
  localparam logic [7:0] C_PID = 8'h2f;
  localparam logic [7:0] C_INV = 8'h64;
  // percent in 0.1 units, frequency in 0.01 hz
  localparam logic [15:0] PCT_FULL = 16'h03e8;
  localparam logic [15:0] PCT_HALF = 16'h01f4;
  localparam logic [11:0] ADC_4MA = 12'h333;
  localparam logic [11:0] ADC_SPAN_MA = 12'hccc;
  localparam logic [11:0] ADC_5V = 12'h800;
  localparam logic [11:0] ADC_10V = 12'hfff;
  // reset values
  localparam logic [7:0] R_ACT = 8'h00;
  localparam logic [7:0] R_INS = 8'hff;
  localparam logic [7:0] R_OS = 8'h00;
  localparam logic [1:0] R_SCL = 2'h0;
  localparam logic [15:0] R_BIA = 16'h0000;
  localparam logic [15:0] R_GAI = 16'h1388;
  localparam logic [15:0] R_ASW = 16'h270f;
  typedef enum logic [1:0] {SC_MA, SC_5V, SC_10V} dpt_scale_t;
endpackage : dpt_pkg

// ---- verilog/dpt_core.sv ----
// dancer roller pid trim: settings, status outputs and speed sum
// Summary of operation
// - action code zero or select input off: plain speed, no dancer trim
// - select input from terminal or network bit, either one works
// - select input lives on a terminal whose selection code is 14
// - no terminal mapped: dancer runs from the action code alone
// - position on analog input 4; scaling 0 4-20mA, 1 0-5V, 2 0-10V
// - upper flag when position above maximum, dancer only, max not 9999
// - lower flag when position below minimum, dancer only, min not 9999
// - forward flag high while forward shown, low on reverse or stop
// - output code 100 or more drives its function inverted
// - pid active flag high while dancer pid runs, codes 47 or 147
// - action codes 40..43: reverse/forward, fixed/ratio addition
// - ratio mode adds pid output times main speed ratio
// - ratio uses gain point as 100% and bias point as 0%; the code divides the pid frequency by gain, so 0% is zero frequency
// - select on while running holds output frequency as main speed
// - controlled variable maps linearly from bias to gain frequency
// - set point 9999 means 50%, else scaled between bias and gain
// - auto switchover frequency setting is ignored in dancer mode
// - thermistor level not 9999 removes terminal 2 as main source
`timescale 1ns/1ns
`default_nettype none
module dpt_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [dpt_pkg::N_IN-1:0] term_i,
  input wire logic [11:0] ain4_i,
  input wire logic [15:0] t2_main_i,
  input wire logic [15:0] alt_main_i,
  input wire logic t2_src_i,
  input wire logic signed [15:0] pid_out_i,
  input wire logic [15:0] out_freq_i,
  input wire logic run_i,
  input wire logic fwd_i,
  input wire logic stop_i,
  output logic [1:0] term_out_o,
  output logic [15:0] freq_cmd_o,
  output logic [15:0] meas_pct_o,
  output logic [15:0] set_pct_o,
  output logic [15:0] set_freq_o,
  output logic pid_reverse_o,
  output logic pid_active_o
);
  import dpt_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // settings
  logic [7:0] act;
  logic [15:0] upr, lwr, spt, thm, bia, gai, asw, sus;
  logic [7:0] ins [N_IN];
  logic [7:0] osa, osb;
  logic [1:0] scl;
  logic net_sel;
  logic [31:0] rd;
  logic [15:0] frq;

  // byte-lane merge of a write into a 16-bit setting
  function automatic logic [15:0] mrg(input logic [15:0] o,
                                      input logic [31:0] d,
                                      input logic [3:0] s);
    mrg = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction : mrg

  // output terminal function: code below 100 true, 100 up inverted
  function automatic logic ofn(input logic [7:0] c,
                               input logic [3:0] f);
    logic [7:0] b;
    logic v;
    b = (c >= C_INV) ? 8'(c - C_INV) : c;
    case (b)
      C_DN: v = f[B_DN];
      C_UP: v = f[B_UP];
      C_FW: v = f[B_FW];
      C_PID: v = f[B_ACT];
      default: v = 1'b0;
    endcase
    ofn = (c >= C_INV) ? ~v : v;
  endfunction : ofn

  ////////////////////////////////////////////////////////////////////
  // wishbone slave, one wait state, unmapped reads return zero
  wire req = cyc_i & stb_i & ~ack_o;
  wire wr = req & we_i;
  // word index of the input selection block, kept in three bits so 0x20 gives 4
  wire [2:0] ix_lo = adr_i[4:2] - 3'h4;
  wire [3:0] ix = {1'b0, ix_lo};
  wire in_hit = (adr_i >= A_IN0) && (adr_i < A_OSA);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= req;
      dat_o <= req ? rd : 32'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act <= R_ACT;
      upr <= NOFN;
      lwr <= NOFN;
      spt <= NOFN;
      osa <= R_OS;
      osb <= R_OS;
      scl <= R_SCL;
      net_sel <= 1'b0;
      thm <= NOFN;
      bia <= R_BIA;
      gai <= R_GAI;
      asw <= R_ASW;
      sus <= NOFN;
    end else if (wr) begin
      case (adr_i)
        A_ACT: if (sel_i[0]) act <= dat_i[7:0];
        A_UPR: upr <= mrg(upr, dat_i, sel_i);
        A_LWR: lwr <= mrg(lwr, dat_i, sel_i);
        A_SPT: spt <= mrg(spt, dat_i, sel_i);
        A_OSA: if (sel_i[0]) osa <= dat_i[7:0];
        A_OSB: if (sel_i[0]) osb <= dat_i[7:0];
        A_SCL: if (sel_i[0]) scl <= dat_i[1:0];
        A_CTL: if (sel_i[0]) net_sel <= dat_i[B_NET];
        A_THM: thm <= mrg(thm, dat_i, sel_i);
        A_BIA: bia <= mrg(bia, dat_i, sel_i);
        A_GAI: gai <= mrg(gai, dat_i, sel_i);
        A_ASW: asw <= mrg(asw, dat_i, sel_i);
        A_SUS: sus <= mrg(sus, dat_i, sel_i);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < N_IN; i++) begin
      if (rst_i)
        ins[i] <= R_INS;
      else if (wr && in_hit && ix == 4'(i) && sel_i[0])
        ins[i] <= dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // terminal inputs: three flops, taken when the last two agree
  logic [N_IN-1:0] ts1, ts2, ts3, tq;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ts1 <= '0;
      ts2 <= '0;
      ts3 <= '0;
      tq <= '0;
    end else begin
      ts1 <= term_i;
      ts2 <= ts1;
      ts3 <= ts2;
      tq <= (ts2 == ts3) ? ts3 : tq;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // dancer enable
  logic [N_IN-1:0] map;
  always_comb begin
    for (int i = 0; i < N_IN; i++)
      map[i] = (ins[i] == C_SEL);
  end
  wire mapped = |map;
  wire sel_on = |(map & tq) | net_sel;
  wire dancer = (act >= C_ACT0) && (act <= C_ACT3);
  // asw is kept for readback only and steers nothing
  wire active = dancer && (mapped ? sel_on : 1'b1);
  wire ratio = act[1];
  wire rev = ~act[0];

  ////////////////////////////////////////////////////////////////////
  // measured value in 0.1 percent
  logic [31:0] mraw;
  always_comb begin
    case (dpt_scale_t'(scl))
      SC_MA: mraw = (ain4_i <= ADC_4MA) ? 32'h0 :
        32'(ain4_i - ADC_4MA) * 32'(PCT_FULL) / 32'(ADC_SPAN_MA);
      SC_5V: mraw = 32'(ain4_i) * 32'(PCT_FULL) / 32'(ADC_5V);
      SC_10V: mraw = 32'(ain4_i) * 32'(PCT_FULL) / 32'(ADC_10V);
      default: mraw = 32'h0;
    endcase
  end
  wire [15:0] meas = (mraw > 32'(PCT_FULL)) ? PCT_FULL : mraw[15:0];
  wire [15:0] setp = (spt == NOFN) ? PCT_HALF : spt;

  ////////////////////////////////////////////////////////////////////
  // frequency arithmetic, signed 34 bits
  wire signed [33:0] span = 34'(signed'({1'b0, gai})) - 34'(signed'({1'b0, bia}));
  // percent to frequency, 0% at bias, 100% at gain
  function automatic logic signed [33:0] p2f(input logic signed [33:0] p,
                                             input logic signed [33:0] s,
                                             input logic [15:0] b);
    p2f = 34'(signed'({1'b0, b})) + (s * p) / 34'sd1000;
  endfunction : p2f

  wire signed [33:0] sf = p2f(34'(signed'({1'b0, setp})), span, bia);
  wire signed [33:0] pf = p2f(34'(pid_out_i), span, bia);

  // main source, terminal 2 dropped when used for the thermistor
  wire t2_ok = (thm == NOFN);
  wire [15:0] main = (t2_src_i && t2_ok) ? t2_main_i : alt_main_i;

  // held output frequency replaces main speed on select while running
  logic hold, sel_d;
  logic [15:0] hfreq;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold <= 1'b0;
      sel_d <= 1'b0;
      hfreq <= 16'h0;
    end else begin
      sel_d <= sel_on;
      if (mapped && active && !sel_d && run_i) begin
        hold <= 1'b1;
        hfreq <= out_freq_i;
      end else if (!active) begin
        hold <= 1'b0;
      end
    end
  end
  wire [15:0] base = hold ? hfreq : main;

  // ratio of main speed, pid frequency over gain point: gain as 100, zero frequency as 0
  wire signed [33:0] rtr = (gai == 16'h0) ? 34'sd0 :
    (pf * 34'(signed'({1'b0, base}))) / 34'(signed'({1'b0, gai}));
  wire signed [33:0] trim = ratio ? rtr : pf;
  wire signed [33:0] sum = 34'(signed'({1'b0, base})) + trim;
  wire [15:0] sumc = (sum < 0) ? 16'h0 :
    (sum > 34'sd65535) ? 16'hffff : sum[15:0];
  wire [15:0] next_frq_w;
  assign next_frq_w = active ? sumc : main;

  ////////////////////////////////////////////////////////////////////
  // status flags and outputs
  logic [3:0] flg;
  wire up_on = active && (upr != NOFN) && (meas > upr);
  wire dn_on = active && (lwr != NOFN) && (meas < lwr);
  wire fw_on = fwd_i && !stop_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flg <= 4'h0;
      frq <= 16'h0;
      meas_pct_o <= 16'h0;
      set_pct_o <= PCT_HALF;
      set_freq_o <= 16'h0;
      pid_reverse_o <= 1'b0;
      term_out_o <= 2'h0;
    end else begin
      flg <= {active, fw_on, dn_on, up_on};
      frq <= next_frq_w;
      meas_pct_o <= meas;
      set_pct_o <= setp;
      set_freq_o <= (sf < 0) ? 16'h0 : sf[15:0];
      pid_reverse_o <= rev;
      term_out_o <= {ofn(osb, flg), ofn(osa, flg)};
    end
  end
  assign freq_cmd_o = frq;
  assign pid_active_o = flg[B_ACT];

  // read mux
  wire [7:0] in_rd = in_hit && (ix < 4'(N_IN)) ? ins[3'(ix)] : 8'h0;
  always_comb begin
    case (adr_i)
      A_ACT: rd = {24'h0, act};
      A_UPR: rd = {16'h0, upr};
      A_LWR: rd = {16'h0, lwr};
      A_SPT: rd = {16'h0, spt};
      A_OSA: rd = {24'h0, osa};
      A_OSB: rd = {24'h0, osb};
      A_SCL: rd = {30'h0, scl};
      A_CTL: rd = {31'h0, net_sel};
      A_THM: rd = {16'h0, thm};
      A_BIA: rd = {16'h0, bia};
      A_GAI: rd = {16'h0, gai};
      A_ASW: rd = {16'h0, asw};
      A_SUS: rd = {16'h0, sus};
      A_STA: rd = {27'h0, hold, flg};
      A_FRQ: rd = {meas, frq};
      default: rd = {24'h0, in_rd};
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_idle_plain;
    (!rst_i && !active) |=> freq_cmd_o == $past(main);
  endproperty
  a_idle_plain: assert property (p_idle_plain) else $error("trim while idle");

  property p_no_map;
    (!mapped && dancer) |=> pid_active_o;
  endproperty
  a_no_map: assert property (p_no_map) else $error("unmapped enable lost");

  property p_net;
    (mapped && dancer && net_sel) |=> pid_active_o;
  endproperty
  a_net: assert property (p_net) else $error("network select ignored");

  property p_upper;
    (active && upr != NOFN && meas > upr) |=> flg[B_UP];
  endproperty
  a_upper: assert property (p_upper) else $error("upper flag missing");

  property p_lower;
    (active && lwr != NOFN && meas < lwr) |=> flg[B_DN];
  endproperty
  a_lower: assert property (p_lower) else $error("lower flag missing");

  property p_quiet;
    !active |=> !flg[B_UP] && !flg[B_DN];
  endproperty
  a_quiet: assert property (p_quiet) else $error("limit flag while idle");

  property p_fwd;
    stop_i |=> !flg[B_FW];
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward flag on stop");

  property p_inv;
    (osa == C_INV + C_PID) ##1 (osa == C_INV + C_PID) |=>
      term_out_o[0] == !$past(flg[B_ACT]);
  endproperty
  a_inv: assert property (p_inv) else $error("inverted output wrong");

  property p_half;
    (spt == NOFN) |=> set_pct_o == PCT_HALF;
  endproperty
  a_half: assert property (p_half) else $error("set point not half");

  property p_therm;
    (thm != NOFN && !active) |=> freq_cmd_o == $past(alt_main_i);
  endproperty
  a_therm: assert property (p_therm) else $error("terminal 2 used");

  property p_ack;
    req |=> ack_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer timing");

  c_ratio: cover property (active && ratio && hold);
  c_upper: cover property (flg[B_UP] ##1 !flg[B_UP]);
  c_fixed: cover property (active && !ratio ##[1:4] !active);
endmodule : dpt_core
`default_nettype wire

// ---- verif/dpt_sensor_model.sv ----
// roller position sensor model driving the terminal 4 adc code
`timescale 1ns/1ns
`default_nettype none
module dpt_sensor_model (
  input wire logic clk_i,
  input wire logic [1:0] scale_i,
  input wire logic [15:0] pct_i,
  output logic [11:0] ain4_o
);
  import dpt_pkg::*;
  logic [23:0] code;
  always_comb begin
    case (scale_i)
      2'h0: code = 24'(ADC_4MA) + 24'(ADC_SPAN_MA) * 24'(pct_i) / 24'h0003e8;
      2'h1: code = 24'(ADC_5V) * 24'(pct_i) / 24'h0003e8;
      default: code = 24'(ADC_10V) * 24'(pct_i) / 24'h0003e8;
    endcase
  end
  always_ff @(posedge clk_i) ain4_o <= code[11:0];
endmodule : dpt_sensor_model
`default_nettype wire

// ---- verif/tb_dancer_pid_speed_trim.sv ----
// self-checking bench for the dancer pid trim core
`timescale 1ns/1ns
`default_nettype none
module tb_dancer_pid_speed_trim;
  import dpt_pkg::*;
  typedef struct {logic [47:0] m; logic [47:0] v;} dpt_note_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [N_IN-1:0] term_i = 5'h00;
  logic [15:0] t2_main_i = 16'h0bb8;
  logic [15:0] alt_main_i = 16'h06a4;
  logic [15:0] out_freq_i = 16'h0000;
  logic [15:0] pct = 16'h01f4;
  logic signed [15:0] pid_out_i = 16'sh0000;
  logic t2_src_i = 1'b1;
  logic run_i = 1'b0;
  logic fwd_i = 1'b1;
  logic stop_i = 1'b0;
  logic look = 1'b0;
  logic pick = 1'b0;
  logic [1:0] scl = 2'h0;
  logic [11:0] ain4_i;
  logic [31:0] dat_o;
  logic ack_o;
  logic [1:0] term_out_o;
  logic [15:0] freq_cmd_o, meas_pct_o, set_pct_o, set_freq_o;
  logic pid_reverse_o, pid_active_o;
  logic [47:0] obs, obs2, got;
  logic [7:0] codes [8] = '{8'h0e, 8'h0f, 8'h10, 8'h2f, 8'h72, 8'h73, 8'h74, 8'h93};
  int bad_count = 0;
  int total_checks = 0;
  int cyc_n = 0;
  dpt_note_t notes[$];
  dpt_note_t n;
  assign obs = {set_freq_o, set_pct_o, 12'h000, pid_reverse_o, pid_active_o, term_out_o};
  assign obs2 = {freq_cmd_o, meas_pct_o, 16'h0000};
  ////////////////////////////////////////////////////////////
  dpt_sensor_model sensor (.clk_i(clk_i), .scale_i(scl), .pct_i(pct), .ain4_o(ain4_i));
  dpt_core dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .term_i(term_i), .ain4_i(ain4_i), .t2_main_i(t2_main_i), .alt_main_i(alt_main_i),
    .t2_src_i(t2_src_i), .pid_out_i(pid_out_i), .out_freq_i(out_freq_i), .run_i(run_i),
    .fwd_i(fwd_i), .stop_i(stop_i), .term_out_o(term_out_o), .freq_cmd_o(freq_cmd_o),
    .meas_pct_o(meas_pct_o), .set_pct_o(set_pct_o), .set_freq_o(set_freq_o),
    .pid_reverse_o(pid_reverse_o), .pid_active_o(pid_active_o));
  always #2 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  // k selects a look at the outputs instead of a register read, a[0] the second group
  task automatic chk(input logic k, input logic [7:0] a, input logic [47:0] m,
                     input logic [47:0] v);
    repeat (8) @(posedge clk_i);
    notes.push_back(dpt_note_t'{m, v});
    if (k) begin
      look <= 1'b1;
      pick <= a[0];
      @(posedge clk_i);
      look <= 1'b0;
    end else begin
      bus(1'b0, a, 32'h0);
    end
  endtask : chk
  function automatic logic fsel(input logic [7:0] c, input logic up, input logic dn,
                                input logic fw, input logic ac);
    logic [7:0] b;
    logic f;
    b = (c >= C_INV) ? c - C_INV : c;
    f = (b == C_DN) ? dn : (b == C_UP) ? up : (b == C_FW) ? fw : (b == C_PID) && ac;
    return (c >= C_INV) ? !f : f;
  endfunction : fsel
  ////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      bad_count++;
      end_sim();
    end
  end
  always @(posedge clk_i) begin
    if (((ack_o === 1'b1 && we_i === 1'b0) || look) && notes.size() > 0) begin
      n = notes.pop_front();
      got = look ? (pick ? obs2 : obs) : {16'h0000, dat_o};
      total_checks++;
      if ((got & n.m) !== n.v) begin
        bad_count++;
        $display("wrong value at %0t: got %h want %h", $time, got & n.m, n.v);
      end
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    int mn, pd, c, p;
    logic e;
    void'($urandom(74593));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(0, A_STA, 48'hf, 48'h4);
    chk(1, 8'h00, {32'hffffffff, 16'h0004}, {16'h09c4, 16'h01f4, 16'h0000});
    chk(0, A_FRQ, 48'hffffffff, 48'h01f40bb8);
    chk(1, 8'h01, {32'hffffffff, 16'h0}, {16'h0bb8, 16'h01f4, 16'h0});
    bus(1'b1, A_THM, 32'h64);
    chk(0, A_FRQ, 48'hffff, 48'h06a4);
    bus(1'b1, A_THM, 32'h270f);
    for (c = 40; c < 44; c++) begin
      bus(1'b1, A_ACT, 32'(c));
      chk(1, 8'h00, 48'hc, {44'h0, ~c[0], 1'b1, 2'h0});
    end
    bus(1'b1, A_SUS, 32'h270f);
    bus(1'b1, A_ASW, 32'h64);
    bus(1'b1, A_ACT, 32'h29);
    for (c = 0; c < 4; c++) begin
      mn = $urandom % 20000;
      pd = $urandom % 1001;
      t2_main_i <= 16'(mn);
      pid_out_i <= 16'(pd);
      chk(0, A_FRQ, 48'hffff, 48'(mn + 5 * pd));
      chk(1, 8'h01, {16'hffff, 32'h0}, {16'(mn + 5 * pd), 32'h0});
    end
    bus(1'b1, A_ACT, 32'h2b);
    pid_out_i <= 16'sh00c8;
    for (c = 1; c < 3; c++) begin
      t2_main_i <= 16'(2500 * c);
      chk(0, A_FRQ, 48'hffff, 48'(3000 * c));
    end
    bus(1'b1, A_ACT, 32'h29);
    bus(1'b1, A_UPR, 32'h258);
    bus(1'b1, A_LWR, 32'h12c);
    for (c = 0; c < 9; c++) begin
      if (c == 7) continue;
      p = (c % 3) * 500;
      bus(1'b1, A_SCL, 32'(c / 3));
      scl <= 2'(c / 3);
      pct <= 16'(p);
      chk(0, A_FRQ, 48'hffff0000, 48'(p << 16));
      chk(1, 8'h01, {16'h0, 16'hffff, 16'h0}, {16'h0, 16'(p), 16'h0});
      chk(0, A_STA, 48'h3, 48'({p < 300, p > 600}));
    end
    bus(1'b1, A_SCL, 32'h0);
    scl <= 2'h0;
    pct <= 16'h03e8;
    bus(1'b1, A_UPR, 32'h270f);
    chk(0, A_STA, 48'h1, 48'h0);
    bus(1'b1, A_UPR, 32'h258);
    bus(1'b1, A_ACT, 32'h0);
    chk(0, A_STA, 48'h1, 48'h0);
    bus(1'b1, A_ACT, 32'h29);
    for (c = 0; c < 16; c++) begin
      stop_i <= (c >= 8);
      bus(1'b1, A_OSA, 32'(codes[c % 8]));
      bus(1'b1, A_OSB, 32'(codes[c % 8]));
      e = fsel(codes[c % 8], 1'b1, 1'b0, c < 8, 1'b1);
      chk(1, 8'h00, 48'h3, {46'h0, e, e});
    end
    stop_i <= 1'b0;
    bus(1'b1, A_IN0 + 8'h08, 32'h0e);
    chk(0, A_STA, 48'h8, 48'h0);
    t2_main_i <= 16'h0bb8;
    pid_out_i <= 16'sh0064;
    run_i <= 1'b1;
    out_freq_i <= 16'h04d2;
    term_i <= 5'h04;
    chk(0, A_FRQ, 48'hffff, 48'h06c6);
    chk(0, A_STA, 48'h18, 48'h18);
    term_i <= 5'h00;
    chk(0, A_FRQ, 48'hffff, 48'h0bb8);
    chk(0, A_STA, 48'h18, 48'h0);
    bus(1'b1, A_CTL, 32'h1);
    chk(0, A_STA, 48'h8, 48'h8);
    chk(0, A_FRQ, 48'hffff, 48'h06c6);
    bus(1'b1, A_CTL, 32'h0);
    chk(0, A_STA, 48'h8, 48'h0);
    bus(1'b1, A_SPT, 32'hc8);
    chk(1, 8'h00, {32'hffffffff, 16'h0}, {16'h03e8, 16'h00c8, 16'h0});
    repeat (4) @(posedge clk_i);
    end_sim();
  end
endmodule : tb_dancer_pid_speed_trim
`default_nettype wire
